// ---- fjie_pkg.sv ----
// constants and types for the jump and increment execution block
package fjie_pkg;
   // instruction word and operand widths
   localparam int WORD_W   = 16;
   localparam int DATA_W   = 8;
   localparam int PC_W     = 21;
   localparam int TGT_W    = 20;
   // far jump encoding: first word opcode byte, second word marker
   localparam logic [7:0] JMP_OP1    = 8'hef;
   localparam logic [3:0] JMP_OP2    = 4'hf;
   // increment encoding: top six bits, then destination and bank bits
   localparam logic [5:0] INC_OP     = 6'h0a;
   localparam int         INC_OP_LSB = 10;
   localparam int         DEST_BIT   = 9;
   localparam int         BANK_BIT   = 8;
   // destination and bank select values
   localparam logic DEST_ACC  = 1'h0;
   localparam logic BANK_FIX  = 1'h0;
   // fixed access bank: low half in bank 0, high half in bank 15
   localparam logic [3:0] ACC_LO_BANK = 4'h0;
   localparam logic [3:0] ACC_HI_BANK = 4'hf;
   localparam int         ACC_SPLIT   = 7;
   // flag positions in the status vector
   localparam int FLAG_W = 5;
   localparam int FL_C   = 0;
   localparam int FL_DC  = 1;
   localparam int FL_Z   = 2;
   localparam int FL_OV  = 3;
   localparam int FL_N   = 4;
   // reset values
   localparam logic [PC_W-1:0]   PC_RST   = 21'h000000;
   localparam logic [FLAG_W-1:0] FLAG_RST = 5'h00;
   localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
   // clock phases of one instruction cycle, one-hot
   typedef enum logic [3:0] {
      PH_Q1 = 4'h1,
      PH_Q2 = 4'h2,
      PH_Q3 = 4'h4,
      PH_Q4 = 4'h8
   } fjie_phase_t;
   // operation in progress, one-hot
   typedef enum logic [2:0] {
      OP_NONE = 3'h1,
      OP_INC  = 3'h2,
      OP_JMP  = 3'h4
   } fjie_op_t;
endpackage

// ---- fjie_alu_if.sv ----
// operand and result path between the sequencer and the incrementer
`timescale 1ns/10ps
interface fjie_alu_if;
   logic [fjie_pkg::DATA_W-1:0] operand;
   logic [fjie_pkg::DATA_W-1:0] result;
   logic [fjie_pkg::FLAG_W-1:0] flags;
   modport seq (output operand, input result, input flags);
   modport alu (input operand, output result, output flags);
endinterface

// ---- fjie_inc_alu.sv ----
// byte incrementer with flag generation
`timescale 1ns/10ps
module fjie_inc_alu (
   // operand in, result and flags out
   fjie_alu_if.alu alu
);
   logic [fjie_pkg::DATA_W:0]   sum;
   logic [4:0]                  low_sum;
   logic [fjie_pkg::DATA_W-1:0] opd;

   // sum with carry out, and the low nibble sum for the half-byte carry
   assign opd        = alu.operand;
   assign sum        = {1'h0, opd} + 9'h001;
   assign low_sum    = {1'h0, opd[3:0]} + 5'h01;
   assign alu.result = sum[fjie_pkg::DATA_W-1:0];

   // flags follow the sum; overflow only when 0x7f rolls to 0x80
   assign alu.flags[fjie_pkg::FL_C]  = sum[fjie_pkg::DATA_W];
   assign alu.flags[fjie_pkg::FL_DC] = low_sum[4];
   assign alu.flags[fjie_pkg::FL_Z]  = (sum[7:0] == 8'h00);
   assign alu.flags[fjie_pkg::FL_OV] = ~opd[7] & sum[7];
   assign alu.flags[fjie_pkg::FL_N]  = sum[7];
endmodule

// ---- fjie_exec.sv ----
// execution sequencer for the far jump and register increment
//
// What this block does
// - a far jump loads its 20-bit literal into program counter bits 20:1.
// - a far jump spans two words and two cycles, the second one idle.
// - a far jump reaches all of program space with no flag dependence.
// - the increment instruction adds one to the addressed register.
// - destination bit 0 writes the accumulator, 1 writes the register.
// - bank bit 0 selects the fixed access bank, ignoring the pointer.
// - bank bit 1 combines the address with the bank pointer.
// - increment updates carry, half-carry, negative, overflow and zero.
`timescale 1ns/10ps
module fjie_exec #(
   parameter int BANK_W = 4
) (
   // clock and reset
   input  wire logic                          clk_i,
   input  wire logic                          rstn_i,
   // instruction words from fetch
   input  wire logic                          instr_valid_i,
   input  wire logic [fjie_pkg::WORD_W-1:0]   fetch_word_i,
   input  wire logic [fjie_pkg::WORD_W-1:0]   fetch_word2_i,
   // bank pointer and data memory read data
   input  wire logic [BANK_W-1:0]             bank_pointer_i,
   input  wire logic [fjie_pkg::DATA_W-1:0]   dm_rdata_i,
   // data memory access
   output logic                               dm_rd_o,
   output logic                               dm_wr_o,
   output logic [BANK_W+7:0]                  dm_addr_o,
   output logic [fjie_pkg::DATA_W-1:0]        dm_wdata_o,
   // working accumulator write
   output logic                               acc_wr_o,
   output logic [fjie_pkg::DATA_W-1:0]        acc_data_o,
   // status flags
   output logic [fjie_pkg::FLAG_W-1:0]        flags_o,
   // program counter and pipeline refill
   output logic                               pc_wr_o,
   output logic [fjie_pkg::PC_W-1:0]          program_counter_o,
   output logic                               refill_o,
   output logic                               phase1_o
);
   // bank width must fit the access bank codes
   if (BANK_W < 4 || BANK_W > 8) begin : g_chk
      $error("fjie_exec: BANK_W must be 4 to 8");
   end

   fjie_alu_if alu_bus ();

   fjie_pkg::fjie_phase_t       phase_ff;
   fjie_pkg::fjie_phase_t       nxt_phase;
   fjie_pkg::fjie_op_t          op_ff;
   fjie_pkg::fjie_op_t          nxt_op;
   logic [fjie_pkg::WORD_W-1:0] instr_ff;
   logic [7:0]                  jlow_ff;
   logic [fjie_pkg::DATA_W-1:0] rdata_ff;
   logic [fjie_pkg::DATA_W-1:0] res_ff;
   logic [fjie_pkg::FLAG_W-1:0] resfl_ff;
   logic                        accept;
   logic                        is_jmp;
   logic                        is_inc;
   logic                        in_q1;
   logic                        in_q2;
   logic                        in_q3;
   logic                        in_q4;
   logic                        dest_acc;
   logic [BANK_W-1:0]           fix_bank;
   logic [BANK_W-1:0]           sel_bank;
   logic [fjie_pkg::TGT_W-1:0]  target;

   fjie_inc_alu u_alu (
      .alu (alu_bus.alu)
   );

   // phase decode and instruction decode at the first phase
   assign in_q1  = (phase_ff == fjie_pkg::PH_Q1);
   assign in_q2  = (phase_ff == fjie_pkg::PH_Q2);
   assign in_q3  = (phase_ff == fjie_pkg::PH_Q3);
   assign in_q4  = (phase_ff == fjie_pkg::PH_Q4);
   assign accept = in_q1 & instr_valid_i & ~refill_o;
   assign is_jmp = (fetch_word_i[15:8] == fjie_pkg::JMP_OP1);
   assign is_inc = (fetch_word_i[15:fjie_pkg::INC_OP_LSB] == fjie_pkg::INC_OP);

   // bank selection from the freshly fetched word
   // fixed access bank
   assign fix_bank = fetch_word_i[fjie_pkg::ACC_SPLIT]
                   ? BANK_W'(fjie_pkg::ACC_HI_BANK)
                   : BANK_W'(fjie_pkg::ACC_LO_BANK);
   assign sel_bank = (fetch_word_i[fjie_pkg::BANK_BIT] == fjie_pkg::BANK_FIX)
                   ? fix_bank : bank_pointer_i;
   assign dest_acc = (instr_ff[fjie_pkg::DEST_BIT] == fjie_pkg::DEST_ACC);

   assign target = {fetch_word2_i[11:0], jlow_ff};

   // the incrementer sees the captured register value
   assign alu_bus.operand = rdata_ff;

   // phase walk and operation selection
   always_comb begin
      nxt_op = op_ff;
      case (phase_ff)
         fjie_pkg::PH_Q1: begin
            nxt_phase = fjie_pkg::PH_Q2;
            if (accept && is_jmp) begin
               nxt_op = fjie_pkg::OP_JMP;
            end else if (accept && is_inc) begin
               nxt_op = fjie_pkg::OP_INC;
            end else begin
               nxt_op = fjie_pkg::OP_NONE;
            end
         end
         fjie_pkg::PH_Q2: nxt_phase = fjie_pkg::PH_Q3;
         fjie_pkg::PH_Q3: nxt_phase = fjie_pkg::PH_Q4;
         fjie_pkg::PH_Q4: begin
            nxt_phase = fjie_pkg::PH_Q1;
            nxt_op    = fjie_pkg::OP_NONE;
         end
         default: begin
            nxt_phase = fjie_pkg::PH_Q1;
            nxt_op    = fjie_pkg::OP_NONE;
         end
      endcase
   end

   // sequencer state
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         phase_ff <= fjie_pkg::PH_Q1;
         op_ff    <= fjie_pkg::OP_NONE;
         phase1_o <= 1'b1;
      end else begin
         phase_ff <= nxt_phase;
         op_ff    <= nxt_op;
         phase1_o <= (nxt_phase == fjie_pkg::PH_Q1);
      end
   end

   // decode phase latches word and drives the read address
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         instr_ff  <= 16'h0000;
         dm_rd_o   <= 1'b0;
         dm_addr_o <= '0;
      end else begin
         dm_rd_o <= accept & is_inc & ~is_jmp;
         if (accept) begin
            instr_ff  <= fetch_word_i;
            dm_addr_o <= {sel_bank, fetch_word_i[7:0]};
         end
      end
   end

   // read in phase 2, process in phase 3
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rdata_ff <= fjie_pkg::DATA_RST;
         res_ff   <= fjie_pkg::DATA_RST;
         resfl_ff <= fjie_pkg::FLAG_RST;
      end else begin
         if (in_q2 && op_ff == fjie_pkg::OP_INC) begin
            rdata_ff <= dm_rdata_i;
         end
         if (in_q3 && op_ff == fjie_pkg::OP_INC) begin
            res_ff   <= alu_bus.result;
            resfl_ff <= alu_bus.flags;
         end
      end
   end

   // destination write in phase 4, one port pulses
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         dm_wr_o    <= 1'b0;
         acc_wr_o   <= 1'b0;
         dm_wdata_o <= fjie_pkg::DATA_RST;
         acc_data_o <= fjie_pkg::DATA_RST;
         flags_o    <= fjie_pkg::FLAG_RST;
      end else begin
         dm_wr_o  <= in_q4 & (op_ff == fjie_pkg::OP_INC) & ~dest_acc;
         acc_wr_o <= in_q4 & (op_ff == fjie_pkg::OP_INC) & dest_acc;
         if (in_q4 && op_ff == fjie_pkg::OP_INC) begin
            if (dest_acc) begin
               acc_data_o <= res_ff;
            end else begin
               dm_wdata_o <= res_ff;
            end
            flags_o <= resfl_ff;
         end
      end
   end

   // jump: low byte in phase 2, counter write in phase 4, idle cycle after.
   // the second word is not checked for its marker nibble; the fetch side
   // only presents a valid pair, so a malformed pair still jumps.
   always_ff @(posedge clk_i or negedge rstn_i) begin
      if (!rstn_i) begin
         jlow_ff           <= 8'h00;
         pc_wr_o           <= 1'b0;
         program_counter_o <= fjie_pkg::PC_RST;
         refill_o          <= 1'b0;
      end else begin
         if (in_q2 && op_ff == fjie_pkg::OP_JMP) begin
            jlow_ff <= instr_ff[7:0];
         end
         pc_wr_o <= in_q4 & (op_ff == fjie_pkg::OP_JMP);
         if (in_q4 && op_ff == fjie_pkg::OP_JMP) begin
            program_counter_o <= {target, 1'b0};
         end
         if (in_q4) begin
            refill_o <= (op_ff == fjie_pkg::OP_JMP);
         end
      end
   end

   // checks on the sequencing
   logic acc_jmp;
   logic acc_inc;
   assign acc_jmp = accept & is_jmp;
   assign acc_inc = accept & is_inc & ~is_jmp;

   property p_jmp_target;
      @(posedge clk_i) disable iff (!rstn_i)
      pc_wr_o |-> program_counter_o ==
                  {$past(fetch_word2_i[11:0]), jlow_ff, 1'b0};
   endproperty
   a_jmp_target: assert property (p_jmp_target)
      else $error("jump target not loaded");

   property p_jmp_two_cycles;
      @(posedge clk_i) disable iff (!rstn_i)
      pc_wr_o |-> refill_o[*4] ##1 !refill_o;
   endproperty
   a_jmp_two_cycles: assert property (p_jmp_two_cycles)
      else $error("jump idle cycle wrong length");

   property p_jmp_always;
      @(posedge clk_i) disable iff (!rstn_i)
      acc_jmp |-> ##4 pc_wr_o;
   endproperty
   a_jmp_always: assert property (p_jmp_always)
      else $error("jump not taken");

   property p_inc_value;
      @(posedge clk_i) disable iff (!rstn_i)
      acc_inc |-> ##4 ((dm_wr_o ? dm_wdata_o : acc_data_o)
                       == 8'($past(dm_rdata_i, 3) + 8'h01));
   endproperty
   a_inc_value: assert property (p_inc_value)
      else $error("increment result wrong");

   property p_inc_dest;
      @(posedge clk_i) disable iff (!rstn_i)
      acc_inc |-> ##4 ((acc_wr_o == !$past(fetch_word_i[9], 4)) &&
                       (dm_wr_o == $past(fetch_word_i[9], 4)));
   endproperty
   a_inc_dest: assert property (p_inc_dest)
      else $error("increment destination wrong");

   property p_bank_fixed;
      @(posedge clk_i) disable iff (!rstn_i)
      acc_inc && !fetch_word_i[8] |=> dm_rd_o &&
         dm_addr_o[BANK_W+7:8] == (dm_addr_o[7] ? BANK_W'(4'hf) : '0);
   endproperty
   a_bank_fixed: assert property (p_bank_fixed)
      else $error("access bank not used");

   property p_bank_ptr;
      @(posedge clk_i) disable iff (!rstn_i)
      acc_inc && fetch_word_i[8] |=>
         dm_addr_o[BANK_W+7:8] == $past(bank_pointer_i);
   endproperty
   a_bank_ptr: assert property (p_bank_ptr)
      else $error("bank pointer not used");

   property p_wrap_flags;
      @(posedge clk_i) disable iff (!rstn_i)
      (dm_wr_o && dm_wdata_o == 8'h00) || (acc_wr_o && acc_data_o == 8'h00)
      |-> flags_o[2] && flags_o[0] && flags_o[1] && !flags_o[4];
   endproperty
   a_wrap_flags: assert property (p_wrap_flags)
      else $error("wrap flags wrong");

   property p_inc_phases;
      @(posedge clk_i) disable iff (!rstn_i)
      acc_inc |=> dm_rd_o ##1 !dm_rd_o ##2 (dm_wr_o || acc_wr_o);
   endproperty
   a_inc_phases: assert property (p_inc_phases)
      else $error("increment phases wrong");

   property p_jmp_low;
      @(posedge clk_i) disable iff (!rstn_i)
      acc_jmp |-> ##4 program_counter_o[8:1] == $past(fetch_word_i[7:0], 4);
   endproperty
   a_jmp_low: assert property (p_jmp_low)
      else $error("jump low byte wrong");

   c_jump: cover property (@(posedge clk_i) disable iff (!rstn_i) pc_wr_o);
   c_to_acc: cover property (@(posedge clk_i) disable iff (!rstn_i)
      acc_wr_o);
   c_to_reg: cover property (@(posedge clk_i) disable iff (!rstn_i)
      dm_wr_o);
   c_wrap: cover property (@(posedge clk_i) disable iff (!rstn_i)
      dm_wr_o && dm_wdata_o == 8'h00);
endmodule

// ---- fjie_dmem_model.sv ----
// data memory model facing the block's register read and write port
`timescale 1ns/10ps
module fjie_dmem_model (
   // clock
   input  wire logic        clk_i,
   // access from the block
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [11:0] addr_i,
   input  wire logic [7:0]  wdata_i,
   output logic [7:0]       rdata_o,
   // preload from the bench
   input  wire logic        ld_i,
   input  wire logic [11:0] ld_addr_i,
   input  wire logic [7:0]  ld_data_i
);
   logic [7:0] mem [4096];
   logic [7:0] last_ff = 8'h5a;
   // data only while a read is up; flipped otherwise so a late
   // capture cannot match by luck
   assign rdata_o = rd_i ? mem[addr_i] : ~last_ff;
   // preloads and writes land on the rising edge
   always @(posedge clk_i) begin
      if (ld_i)
         mem[ld_addr_i] <= ld_data_i;
      else if (wr_i)
         mem[addr_i] <= wdata_i;
      if (rd_i)
         last_ff <= mem[addr_i];
   end
endmodule

// ---- test_far_jump_and_increment_exec.sv ----
// self-checking bench for the far jump and increment sequencer
`timescale 1ns/10ps
module test_far_jump_and_increment_exec;
   logic        clk_i          = 1'b0;
   logic        rstn_i         = 1'b0;
   logic        instr_valid_i  = 1'b0;
   logic [15:0] fetch_word_i   = 16'h0000;
   logic [15:0] fetch_word2_i  = 16'h0000;
   logic [3:0]  bank_pointer_i = 4'h0;
   logic        ld             = 1'b0;
   logic [11:0] ld_addr        = 12'h000;
   logic [7:0]  ld_data        = 8'h00;
   logic [7:0]  dm_rdata_i;
   logic        dm_rd_o, dm_wr_o, acc_wr_o, pc_wr_o, refill_o, phase1_o;
   logic [11:0] dm_addr_o;
   logic [7:0]  dm_wdata_o, acc_data_o;
   logic [4:0]  flags_o;
   logic [20:0] program_counter_o;
   int          error_cnt = 0;
   int          tests_run = 0;
   int          rd_n, wr_n, acc_n, pc_n, rf_n, hit;

   // 40 MHz
   always #12.5 clk_i = ~clk_i;

   fjie_exec #(.BANK_W(4)) i_fjie_exec (
      .clk_i(clk_i), .rstn_i(rstn_i), .instr_valid_i(instr_valid_i),
      .fetch_word_i(fetch_word_i), .fetch_word2_i(fetch_word2_i),
      .bank_pointer_i(bank_pointer_i), .dm_rdata_i(dm_rdata_i),
      .dm_rd_o(dm_rd_o), .dm_wr_o(dm_wr_o), .dm_addr_o(dm_addr_o),
      .dm_wdata_o(dm_wdata_o), .acc_wr_o(acc_wr_o),
      .acc_data_o(acc_data_o), .flags_o(flags_o), .pc_wr_o(pc_wr_o),
      .program_counter_o(program_counter_o), .refill_o(refill_o),
      .phase1_o(phase1_o));

   fjie_dmem_model i_fjie_dmem_model (
      .clk_i(clk_i), .rd_i(dm_rd_o), .wr_i(dm_wr_o), .addr_i(dm_addr_o),
      .wdata_i(dm_wdata_o), .rdata_o(dm_rdata_i), .ld_i(ld),
      .ld_addr_i(ld_addr), .ld_data_i(ld_data));

   // verdict and end of run
   task automatic summarize;
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   // count one comparison, report it at once if it fails
   task automatic check(input logic ok, input string msg);
      tests_run++;
      if (ok !== 1'b1) begin
         error_cnt++;
         $display("unexpected at %0t: %s", $time, msg);
      end
   endtask

   // wait for the edge before a q1 edge, then present a word at it;
   // hold keeps valid up so a caller can offer a word in the refill
   task automatic issue(input logic [15:0] w1, input logic [15:0] w2,
                        input logic hold = 1'b0);
      int n;
      n = 0;
      do begin
         @(posedge clk_i);
         #2;
         n++;
      end while (phase1_o !== 1'b1 && n < 8);
      if (n >= 8) begin
         check(1'b0, "phase marker never seen");
         summarize();
      end
      instr_valid_i = 1'b1;
      fetch_word_i = w1;
      fetch_word2_i = w2;
      @(posedge clk_i);
      #2;
      if (!hold)
         instr_valid_i = 1'b0;
   endtask

   // index i shows what edge i+1 after the accept samples
   task automatic watch(input int cyc);
      rd_n = 0;
      wr_n = 0;
      acc_n = 0;
      pc_n = 0;
      rf_n = 0;
      hit = -1;
      for (int i = 0; i < cyc; i++) begin
         if (i == 6)
            instr_valid_i = 1'b0;
         rd_n += (dm_rd_o === 1'b1);
         wr_n += (dm_wr_o === 1'b1);
         acc_n += (acc_wr_o === 1'b1);
         pc_n += (pc_wr_o === 1'b1);
         rf_n += (refill_o === 1'b1);
         if (dm_wr_o === 1'b1 || acc_wr_o === 1'b1 || pc_wr_o === 1'b1)
            hit = i;
         @(posedge clk_i);
         #2;
      end
   endtask

   // one increment with its expected address, result and flags
   task automatic t_inc(input logic [7:0] f, input logic d, input logic a,
                        input logic [3:0] bank, input logic [7:0] init);
      logic [7:0]  res;
      logic [4:0]  ef;
      logic [11:0] ea;
      res = init + 8'h01;
      ef = 5'h00;
      ef[fjie_pkg::FL_C] = (init == 8'hff);
      ef[fjie_pkg::FL_DC] = (init[3:0] == 4'hf);
      ef[fjie_pkg::FL_Z] = (res == 8'h00);
      ef[fjie_pkg::FL_OV] = (init == 8'h7f);
      ef[fjie_pkg::FL_N] = res[7];
      ea = {f[7] ? fjie_pkg::ACC_HI_BANK : fjie_pkg::ACC_LO_BANK, f};
      if (a)
         ea = {bank, f};
      ld = 1'b1;
      ld_addr = ea;
      ld_data = init;
      bank_pointer_i = bank;
      @(posedge clk_i);
      #2;
      ld = 1'b0;
      issue({fjie_pkg::INC_OP, d, a, f}, 16'h0000);
      watch(6);
      check(rd_n == 1 && hit == 3, "increment timing");
      check(dm_addr_o === ea, "register address");
      check(wr_n == int'(d) && acc_n == int'(!d), "destination");
      check((d ? dm_wdata_o : acc_data_o) === res, "result");
      check(flags_o === ef, "flags");
      check(pc_n == 0, "counter moved on increment");
      $display("test increment f=%h d=%b a=%b done", f, d, a);
   endtask

   // far jump; a late upper word and a word held through the refill
   task automatic t_jump(input logic [19:0] k);
      logic [4:0] fl;
      fl = flags_o;
      issue({fjie_pkg::JMP_OP1, k[7:0]}, {fjie_pkg::JMP_OP2, ~k[19:8]},
            1'b1);
      fetch_word2_i = {fjie_pkg::JMP_OP2, k[19:8]};
      fetch_word_i = {fjie_pkg::INC_OP, 2'b11, 8'h10};
      watch(8);
      check(pc_n == 1 && hit == 3, "counter write timing");
      check(program_counter_o === {k, 1'b0}, "jump target");
      check(rf_n == 4, "refill cycle length");
      check(rd_n == 0 && wr_n == 0, "word taken in refill");
      check(flags_o === fl, "flags moved on jump");
      $display("test jump %h done", k);
   endtask

   // an unrelated opcode must raise no read, write or counter strobe
   task automatic t_other;
      issue(16'h2400, 16'h0000);
      watch(6);
      check(rd_n + wr_n + acc_n + pc_n == 0, "foreign word ran");
      $display("test foreign word done");
   endtask

   initial begin
      repeat (2) @(posedge clk_i);
      #2;
      rstn_i = 1'b1;
      t_inc(8'h10, 1'b1, 1'b1, 4'h3, 8'h41);
      t_inc(8'h85, 1'b0, 1'b0, 4'h7, 8'hff);
      t_inc(8'h20, 1'b1, 1'b0, 4'h5, 8'h7f);
      t_inc(8'hff, 1'b0, 1'b1, 4'hc, 8'h0f);
      t_jump(20'hfffff);
      t_jump(20'h00001);
      t_jump(20'h5a3c6);
      t_other();
      summarize();
   end
endmodule
